// ==== logic/pdce_pkg.sv ====
package pdce_pkg;

  // ****************************************************************
  // Address map
  // ****************************************************************
  localparam logic [31:0] PDCE_BLOCK_BASE  = 32'h4007_0000;
  localparam logic [31:0] PDCE_PORT_STEP   = 32'h0000_0100;
  localparam int          PDCE_PORT_COUNT  = 7;
  localparam logic [31:0] PDCE_OFF_P3_DATA = 32'h0000_031C;
  localparam logic [31:0] PDCE_OFF_P4_HI   = 32'h0000_0400;
  localparam logic [31:0] PDCE_OFF_P4_LO   = 32'h0000_0404;
  localparam logic [31:0] PDCE_OFF_P4_POL  = 32'h0000_0408;
  localparam logic [31:0] PDCE_OFF_P4_IEN  = 32'h0000_040C;
  localparam logic [31:0] PDCE_OFF_P4_PEND = 32'h0000_0410;
  localparam logic [31:0] PDCE_OFF_P4_OUT  = 32'h0000_041C;
  localparam logic [31:0] PDCE_OFF_P4_CLR  = 32'h0000_0420;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] PDCE_RST_P3_DATA = 8'h00;
  localparam logic [7:0] PDCE_RST_P4_HI   = 8'hFF;
  localparam logic [7:0] PDCE_RST_P4_LO   = 8'h00;
  localparam logic [7:0] PDCE_RST_P4_POL  = 8'h00;
  localparam logic [7:0] PDCE_RST_P4_IEN  = 8'h00;
  localparam logic [7:0] PDCE_RST_P4_PEND = 8'h00;
  localparam logic [7:0] PDCE_RST_P4_OUT  = 8'h00;
  localparam logic [7:0] PDCE_RST_PIN_OUT = 8'h80;
  localparam logic [7:0] PDCE_RST_PIN_OEN = 8'h7F;

  // ****************************************************************
  // Pin function codes and pin positions
  // ****************************************************************
  localparam logic [1:0] PDCE_MODE_IN    = 2'h0;
  localparam logic [1:0] PDCE_MODE_OUT   = 2'h1;
  localparam logic [1:0] PDCE_MODE_OD    = 2'h2;
  localparam logic [1:0] PDCE_MODE_ALT   = 2'h3;
  localparam int         PDCE_PIN_TDO    = 7;
  localparam int         PDCE_PIN_TMS    = 6;
  localparam int         PDCE_PIN_TDI    = 5;
  localparam int         PDCE_PIN_TCK    = 4;
  localparam int         PDCE_PIN_TRST   = 3;
  localparam int         PDCE_PIN_PWM    = 2;
  localparam int         PDCE_PIN_CAP    = 1;
  localparam int         PDCE_PIN_TCLK   = 0;
  localparam int         PDCE_FIELD_W    = 2;
  localparam int         PDCE_HALF_PINS  = 4;

endpackage

// ==== logic/pdce_port_block.sv ====
// Summary of operation
// - Port register groups start at 0x4007_0000, stepping 0x100 per port.
// - Port three data at 0x031C, resets zero, bits 31:8 read zero.
// - Port four upper function register at 0x0400 resets to 0xFF.
// - Field code selects input, push-pull, open-drain or alternate function.
// - Alternate code puts debug data out, mode select, data in on 4.7-4.5.
// - Alternate code on pin 4.4 carries the debug test clock in.
// - After reset debug inputs float and debug data out drives high.
// - Software may rewrite debug pins as ordinary inputs or outputs.
// - Port four lower function register at 0x0404 resets to zero.
// - Code 00 on pin 4.3 is input plus debug reset; 11 unused.
// - Alternate code: 4.2 timer wave out, 4.1 capture, 4.0 clock.
// - Polarity register at 0x0408 resets zero, one bit per pin.
// - Polarity bit 0 selects falling edge, 1 selects rising edge.
// - Interrupt enable register at 0x040C, one enable bit per pin.
// - Pending bit reads 1 when pending; writing zero clears it.
module pdce_port_block
  import pdce_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [7:0]  port3_pin_data,
  input  wire logic [7:0]  port4_pin_in,
  output logic      [7:0]  port4_pin_out,
  output logic      [7:0]  port4_pin_oe_n,
  input  wire logic        debug_test_data_out,
  output logic             debug_test_mode_select,
  output logic             debug_test_data_in,
  output logic             debug_test_clock,
  output logic             debug_test_reset_n,
  input  wire logic        timer2_wave_out,
  output logic             timer2_capture_in,
  output logic             timer2_ext_clock_in,
  output logic             port4_irq
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [7:0]  port3_pin_data;
    logic [7:0]  port4_upper_pin_function;
    logic [7:0]  port4_lower_pin_function;
    logic [7:0]  port4_interrupt_polarity;
    logic [7:0]  port4_interrupt_enable;
    logic [7:0]  port4_interrupt_pending;
    logic [7:0]  port4_output_data;
    logic [7:0]  sync_first;
    logic [7:0]  sync_second;
    logic [7:0]  sync_prev;
    logic [7:0]  pin_out;
    logic [7:0]  pin_oe_n;
    logic        tms;
    logic        tdi;
    logic        tck;
    logic        trst_n;
    logic        cap;
    logic        tclk;
    logic [31:0] rdata;
    logic        err;
  } pdce_state_type;

  pdce_state_type state_reg;
  pdce_state_type state_next;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic hit_reg(input logic [31:0] addr,
                                   input logic [31:0] off);
    hit_reg = (addr == PDCE_BLOCK_BASE + off);
  endfunction

  function automatic logic [1:0] pin_mode(input logic [7:0] hi,
                                          input logic [7:0] lo,
                                          input int         pin);
    if (pin >= PDCE_HALF_PINS) begin
      pin_mode = hi[(pin - PDCE_HALF_PINS) * PDCE_FIELD_W +: 2];
    end else begin
      pin_mode = lo[pin * PDCE_FIELD_W +: 2];
    end
  endfunction

  function automatic logic [31:0] widen(input logic [7:0] val);
    widen = {24'h00_0000, val};
  endfunction

  logic       wr_access;
  logic       setup_phase;
  logic       mapped;
  logic [7:0] rise;
  logic [7:0] fall;
  logic [7:0] edge_hit;
  logic [7:0] clear_mask;
  logic [1:0] mode;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    state_next  = state_reg;
    wr_access   = psel & penable & pwrite;
    setup_phase = psel & ~penable;
    mode        = PDCE_MODE_IN;

    // The first stage is read only by the second.
    state_next.sync_first  = port4_pin_in;
    state_next.sync_second = state_reg.sync_first;
    state_next.sync_prev   = state_reg.sync_second;
    rise     = state_reg.sync_second & ~state_reg.sync_prev;
    fall     = ~state_reg.sync_second & state_reg.sync_prev;
    edge_hit = (state_reg.port4_interrupt_polarity & rise) |
               (~state_reg.port4_interrupt_polarity & fall);

    mapped = hit_reg(paddr, PDCE_OFF_P3_DATA) |
             hit_reg(paddr, PDCE_OFF_P4_HI) |
             hit_reg(paddr, PDCE_OFF_P4_LO) |
             hit_reg(paddr, PDCE_OFF_P4_POL) |
             hit_reg(paddr, PDCE_OFF_P4_IEN) |
             hit_reg(paddr, PDCE_OFF_P4_PEND) |
             hit_reg(paddr, PDCE_OFF_P4_OUT) |
             hit_reg(paddr, PDCE_OFF_P4_CLR);

    // Read data is latched in the setup cycle so prdata is a flop.
    if (setup_phase) begin
      state_next.err = ~mapped;
      if (hit_reg(paddr, PDCE_OFF_P3_DATA)) begin
        state_next.rdata = widen(state_reg.port3_pin_data);
      end else if (hit_reg(paddr, PDCE_OFF_P4_HI)) begin
        state_next.rdata = widen(state_reg.port4_upper_pin_function);
      end else if (hit_reg(paddr, PDCE_OFF_P4_LO)) begin
        state_next.rdata = widen(state_reg.port4_lower_pin_function);
      end else if (hit_reg(paddr, PDCE_OFF_P4_POL)) begin
        state_next.rdata = widen(state_reg.port4_interrupt_polarity);
      end else if (hit_reg(paddr, PDCE_OFF_P4_IEN)) begin
        state_next.rdata = widen(state_reg.port4_interrupt_enable);
      end else if (hit_reg(paddr, PDCE_OFF_P4_PEND)) begin
        state_next.rdata = widen(state_reg.port4_interrupt_pending);
      end else if (hit_reg(paddr, PDCE_OFF_P4_OUT)) begin
        state_next.rdata = widen(state_reg.port4_output_data);
      end else begin
        state_next.rdata = 32'h0000_0000;
      end
    end

    clear_mask = 8'h00;
    if (wr_access) begin
      if (hit_reg(paddr, PDCE_OFF_P3_DATA)) begin
        state_next.port3_pin_data = pwdata[7:0];
      end
      if (hit_reg(paddr, PDCE_OFF_P4_HI)) begin
        state_next.port4_upper_pin_function = pwdata[7:0];
      end
      if (hit_reg(paddr, PDCE_OFF_P4_LO)) begin
        state_next.port4_lower_pin_function = pwdata[7:0];
      end
      if (hit_reg(paddr, PDCE_OFF_P4_POL)) begin
        state_next.port4_interrupt_polarity = pwdata[7:0];
      end
      if (hit_reg(paddr, PDCE_OFF_P4_IEN)) begin
        state_next.port4_interrupt_enable = pwdata[7:0];
      end
      if (hit_reg(paddr, PDCE_OFF_P4_OUT)) begin
        state_next.port4_output_data = pwdata[7:0];
      end
      if (hit_reg(paddr, PDCE_OFF_P4_PEND)) begin
        clear_mask = ~pwdata[7:0];
      end
      if (hit_reg(paddr, PDCE_OFF_P4_CLR)) begin
        clear_mask = pwdata[7:0];
      end
    end
    // A new edge wins over a clear in the same cycle.
    state_next.port4_interrupt_pending =
      (state_reg.port4_interrupt_pending & ~clear_mask) | edge_hit;

    // Pin drivers, one per pin, from the function fields.
    for (int i = 0; i < 8; i++) begin
      mode = pin_mode(state_reg.port4_upper_pin_function,
                      state_reg.port4_lower_pin_function, i);
      case (mode)
        PDCE_MODE_IN: begin
          state_next.pin_out[i]  = 1'b0;
          state_next.pin_oe_n[i] = 1'b1;
        end
        PDCE_MODE_OUT: begin
          state_next.pin_out[i]  = state_reg.port4_output_data[i];
          state_next.pin_oe_n[i] = 1'b0;
        end
        PDCE_MODE_OD: begin
          state_next.pin_out[i]  = 1'b0;
          state_next.pin_oe_n[i] = state_reg.port4_output_data[i];
        end
        PDCE_MODE_ALT: begin
          if (i == PDCE_PIN_TDO) begin
            state_next.pin_out[i]  = debug_test_data_out;
            state_next.pin_oe_n[i] = 1'b0;
          end else if (i == PDCE_PIN_PWM) begin
            state_next.pin_out[i]  = timer2_wave_out;
            state_next.pin_oe_n[i] = 1'b0;
          end else begin
            // Alternate inputs, and the unused code on pin 4.3, float.
            state_next.pin_out[i]  = 1'b0;
            state_next.pin_oe_n[i] = 1'b1;
          end
        end
        default: begin
          state_next.pin_out[i]  = 1'b0;
          state_next.pin_oe_n[i] = 1'b1;
        end
      endcase
    end

    // Alternate inputs route from the synchronised pins; idle levels
    // keep the test port and timer quiet when a pin is reassigned.
    state_next.tms = (pin_mode(state_reg.port4_upper_pin_function,
                      state_reg.port4_lower_pin_function, PDCE_PIN_TMS)
                      == PDCE_MODE_ALT) ?
                     state_reg.sync_second[PDCE_PIN_TMS] : 1'b1;
    state_next.tdi = (pin_mode(state_reg.port4_upper_pin_function,
                      state_reg.port4_lower_pin_function, PDCE_PIN_TDI)
                      == PDCE_MODE_ALT) ?
                     state_reg.sync_second[PDCE_PIN_TDI] : 1'b1;
    state_next.tck = (pin_mode(state_reg.port4_upper_pin_function,
                      state_reg.port4_lower_pin_function, PDCE_PIN_TCK)
                      == PDCE_MODE_ALT) ?
                     state_reg.sync_second[PDCE_PIN_TCK] : 1'b0;
    state_next.trst_n = (pin_mode(state_reg.port4_upper_pin_function,
                      state_reg.port4_lower_pin_function, PDCE_PIN_TRST)
                      == PDCE_MODE_IN) ?
                     state_reg.sync_second[PDCE_PIN_TRST] : 1'b0;
    state_next.cap = (pin_mode(state_reg.port4_upper_pin_function,
                      state_reg.port4_lower_pin_function, PDCE_PIN_CAP)
                      == PDCE_MODE_ALT) ?
                     state_reg.sync_second[PDCE_PIN_CAP] : 1'b0;
    state_next.tclk = (pin_mode(state_reg.port4_upper_pin_function,
                      state_reg.port4_lower_pin_function, PDCE_PIN_TCLK)
                      == PDCE_MODE_ALT) ?
                     state_reg.sync_second[PDCE_PIN_TCLK] : 1'b0;
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg                          <= '0;
      state_reg.port3_pin_data           <= PDCE_RST_P3_DATA;
      state_reg.port4_upper_pin_function <= PDCE_RST_P4_HI;
      state_reg.port4_lower_pin_function <= PDCE_RST_P4_LO;
      state_reg.port4_interrupt_polarity <= PDCE_RST_P4_POL;
      state_reg.port4_interrupt_enable   <= PDCE_RST_P4_IEN;
      state_reg.port4_interrupt_pending  <= PDCE_RST_P4_PEND;
      state_reg.port4_output_data        <= PDCE_RST_P4_OUT;
      state_reg.pin_out                  <= PDCE_RST_PIN_OUT;
      state_reg.pin_oe_n                 <= PDCE_RST_PIN_OEN;
      state_reg.tms                      <= 1'b1;
      state_reg.tdi                      <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign prdata                 = state_reg.rdata;
  assign pready                 = psel & penable;
  assign pslverr                = psel & penable & state_reg.err;
  assign port3_pin_data         = state_reg.port3_pin_data;
  assign port4_pin_out          = state_reg.pin_out;
  assign port4_pin_oe_n         = state_reg.pin_oe_n;
  assign debug_test_mode_select = state_reg.tms;
  assign debug_test_data_in     = state_reg.tdi;
  assign debug_test_clock       = state_reg.tck;
  assign debug_test_reset_n     = state_reg.trst_n;
  assign timer2_capture_in      = state_reg.cap;
  assign timer2_ext_clock_in    = state_reg.tclk;
  assign port4_irq              = |(state_reg.port4_interrupt_pending &
                                    state_reg.port4_interrupt_enable);

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_unmapped_err: assert property (
    @(posedge pclk) disable iff (!presetn)
    (setup_phase && !mapped) ##1 (psel && penable) |-> pslverr)
    else $error("unmapped access not answered with an error");

  a_p3_read_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    (setup_phase && !pwrite && hit_reg(paddr, PDCE_OFF_P3_DATA)) |=>
    (prdata[31:8] == 24'h00_0000 && prdata[7:0] == $past(port3_pin_data)))
    else $error("port three data read returned wrong value");

  a_rsvd_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && penable && !pwrite) |-> prdata[31:8] == 24'h00_0000)
    else $error("reserved read data bits not zero");

  a_input_floats: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state_reg.port4_lower_pin_function[1:0] == PDCE_MODE_IN) |=>
    port4_pin_oe_n[0])
    else $error("input mode pin is driven");

  a_od_low: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state_reg.port4_lower_pin_function[1:0] == PDCE_MODE_OD) |=>
    (!port4_pin_out[0] &&
     port4_pin_oe_n[0] == $past(state_reg.port4_output_data[0])))
    else $error("open-drain pin drives high or has wrong enable");

  a_tdo_drives: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state_reg.port4_upper_pin_function[7:6] == PDCE_MODE_ALT) |=>
    (!port4_pin_oe_n[7] && port4_pin_out[7] == $past(debug_test_data_out)))
    else $error("debug data out not driven on pin 4.7");

  a_tck_route: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state_reg.port4_upper_pin_function[1:0] == PDCE_MODE_ALT) ##1
    (state_reg.port4_upper_pin_function[1:0] == PDCE_MODE_ALT) |=>
    debug_test_clock == $past(port4_pin_in[4], 3))
    else $error("debug clock not routed from pin 4.4");

  a_upper_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_access && hit_reg(paddr, PDCE_OFF_P4_HI)) |=>
    state_reg.port4_upper_pin_function == $past(pwdata[7:0]))
    else $error("function register write lost");

  a_lower_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_access && hit_reg(paddr, PDCE_OFF_P4_LO)) |=>
    state_reg.port4_lower_pin_function == $past(pwdata[7:0]))
    else $error("lower function register write lost");

  a_trst_route: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state_reg.port4_lower_pin_function[7:6] == PDCE_MODE_IN) |=>
    debug_test_reset_n == $past(state_reg.sync_second[3]))
    else $error("debug reset not routed from pin 4.3");

  a_pwm_drive: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state_reg.port4_lower_pin_function[5:4] == PDCE_MODE_ALT) |=>
    (!port4_pin_oe_n[2] && port4_pin_out[2] == $past(timer2_wave_out)))
    else $error("timer wave not driven on pin 4.2");

  a_pol_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_access && hit_reg(paddr, PDCE_OFF_P4_POL)) |=>
    state_reg.port4_interrupt_polarity == $past(pwdata[7:0]))
    else $error("polarity register write lost");

  a_rise_sets: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state_reg.port4_interrupt_polarity[0] && rise[0]) |=>
    state_reg.port4_interrupt_pending[0])
    else $error("rising edge did not set pending");

  a_pend_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_access && hit_reg(paddr, PDCE_OFF_P4_PEND) && !pwdata[0] &&
     !edge_hit[0]) |=> !state_reg.port4_interrupt_pending[0])
    else $error("writing zero did not clear pending");

  a_irq_level: assert property (
    @(posedge pclk) disable iff (!presetn)
    (|(edge_hit & state_reg.port4_interrupt_enable) &&
     !(wr_access && hit_reg(paddr, PDCE_OFF_P4_IEN))) |=> port4_irq)
    else $error("enabled edge did not raise interrupt");

  a_edge_latency: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!state_reg.port4_interrupt_polarity[5] &&
     $fell(state_reg.sync_second[5])) |=>
    state_reg.port4_interrupt_pending[5])
    else $error("falling edge did not set pending");

endmodule

// ==== tb/pdce_pin_model.sv ====
// ****************************************************************
// Pads, debug probe and timer on the far side of port four
// ****************************************************************
module pdce_pin_model (
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe_n,
  input  wire logic [7:0] ext_level,
  input  wire logic       tap_level,
  input  wire logic       wave_level,
  output logic      [7:0] pin_in,
  output logic            debug_test_data_out,
  output logic            timer2_wave_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // A pad that the port drives shows the port's level, else the outside's.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_in[i] = pin_oe_n[i] ? ext_level[i] : pin_out[i];
    end
  end
  assign debug_test_data_out = tap_level;
  assign timer2_wave_out     = wave_level;
endmodule

// ==== tb/pdce_port_block_test.sv ====
// ****************************************************************
// Self-checking bench for the port block
// ****************************************************************
`define CHK(n, e, g) chk(n, 32'(e), 32'(g))
module pdce_port_block_test
  import pdce_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata;
  logic [7:0]  port3_pin_data, port4_pin_in, port4_pin_out, port4_pin_oe_n;
  logic [7:0]  ext_level;
  logic        tap_level, wave_level, tdo, tms, tdi, tck, trst_n;
  logic        wave, cap_in, tclk_in, port4_irq;
  int          num_errors = 0;
  int          n_checks = 0;

  pdce_port_block pdce_port_block_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .port3_pin_data(port3_pin_data),
    .port4_pin_in(port4_pin_in), .port4_pin_out(port4_pin_out),
    .port4_pin_oe_n(port4_pin_oe_n), .debug_test_data_out(tdo),
    .debug_test_mode_select(tms), .debug_test_data_in(tdi),
    .debug_test_clock(tck), .debug_test_reset_n(trst_n),
    .timer2_wave_out(wave), .timer2_capture_in(cap_in),
    .timer2_ext_clock_in(tclk_in), .port4_irq(port4_irq));

  pdce_pin_model pdce_pin_model_inst (
    .pin_out(port4_pin_out), .pin_oe_n(port4_pin_oe_n),
    .ext_level(ext_level), .tap_level(tap_level), .wave_level(wave_level),
    .pin_in(port4_pin_in), .debug_test_data_out(tdo),
    .timer2_wave_out(wave));

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic wr_en, input logic [31:0] off, wd,
                     output logic [31:0] rd, output logic err);
    int k;
    @(posedge pclk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr_en;
    paddr   <= PDCE_BLOCK_BASE + off;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'h1 && k < 16);
    if (pready !== 1'h1) begin
      num_errors++;
      tally_and_finish();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [31:0] off, wd);
    logic [31:0] r;
    logic        e;
    apb(1'h1, off, wd, r, e);
  endtask

  task automatic rdchk(input string nm, input logic [31:0] off, e);
    logic [31:0] r;
    logic        er;
    apb(1'h0, off, 32'h0000_0000, r, er);
    `CHK(nm, e, r);
  endtask

  // Waits n edges, then samples on the falling edge where all is settled.
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask

  task automatic pins(input logic [7:0] v);
    @(posedge pclk);
    ext_level <= v;
  endtask

  task automatic test_reset;
    logic [31:0] offs [6] = '{PDCE_OFF_P3_DATA, PDCE_OFF_P4_HI,
      PDCE_OFF_P4_LO, PDCE_OFF_P4_POL, PDCE_OFF_P4_IEN, PDCE_OFF_P4_PEND};
    logic [31:0] exps [6] = '{32'h0, 32'hFF, 32'h0, 32'h0, 32'h0, 32'h0};
    settle(0);
    `CHK("oe_n", 8'h7F, port4_pin_oe_n);
    `CHK("tdo_pad", 1'h1, port4_pin_out[7]);
    for (int i = 0; i < 6; i++) begin
      rdchk("reset_value", offs[i], exps[i]);
    end
    $display("test reset done");
  endtask

  task automatic test_regs;
    logic [31:0] r;
    logic        e;
    wr(PDCE_OFF_P3_DATA, 32'hFFFF_FFA5);
    rdchk("p3_data", PDCE_OFF_P3_DATA, 32'h0000_00A5);
    `CHK("p3_port", 8'hA5, port3_pin_data);
    wr(PDCE_OFF_P4_POL, 32'hFFFF_FF3C);
    rdchk("polarity", PDCE_OFF_P4_POL, 32'h0000_003C);
    wr(PDCE_OFF_P4_HI, 32'hFFFF_FFFF);
    rdchk("upper", PDCE_OFF_P4_HI, 32'h0000_00FF);
    apb(1'h0, 32'h0000_0500, 32'h0, r, e);
    `CHK("unmapped_err", 1'h1, e);
    `CHK("unmapped_data", 32'h0, r);
    $display("test regs done");
  endtask

  task automatic test_irq;
    wr(PDCE_OFF_P4_POL, 32'h0000_0001);
    wr(PDCE_OFF_P4_IEN, 32'h0000_0000);
    pins(8'h05);
    settle(4);
    rdchk("pending", PDCE_OFF_P4_PEND, 32'h0000_0003);
    `CHK("irq_masked", 1'h0, port4_irq);
    wr(PDCE_OFF_P4_IEN, 32'h0000_0002);
    settle(1);
    `CHK("irq_on", 1'h1, port4_irq);
    wr(PDCE_OFF_P4_PEND, 32'hFFFF_FFFD);
    rdchk("pend_clr0", PDCE_OFF_P4_PEND, 32'h0000_0001);
    `CHK("irq_off", 1'h0, port4_irq);
    wr(PDCE_OFF_P4_CLR, 32'h0000_0001);
    pins(8'h04);
    settle(4);
    rdchk("pend_none", PDCE_OFF_P4_PEND, 32'h0000_0000);
    $display("test irq done");
  endtask

  task automatic test_modes;
    logic exp_oe [4] = '{1'h1, 1'h0, 1'h1, 1'h1};
    wr(PDCE_OFF_P4_OUT, 32'h0000_0001);
    for (int c = 0; c < 4; c++) begin
      wr(PDCE_OFF_P4_LO, 32'(c));
      settle(2);
      `CHK("pin0_oe_n", exp_oe[c], port4_pin_oe_n[0]);
      if (c == 1) `CHK("pin0_out", 1'h1, port4_pin_out[0]);
    end
    wr(PDCE_OFF_P4_LO, 32'h0000_0002);
    wr(PDCE_OFF_P4_OUT, 32'h0000_0000);
    settle(2);
    `CHK("od_low", 2'h0, {port4_pin_oe_n[0], port4_pin_out[0]});
    wr(PDCE_OFF_P4_LO, 32'h0000_003F);
    pins(8'h03);
    settle(4);
    `CHK("wave_pad", 2'h1, {port4_pin_oe_n[2], port4_pin_out[2]});
    `CHK("timer_ins", 2'h3, {cap_in, tclk_in});
    $display("test modes done");
  endtask

  task automatic test_debug;
    for (int v = 0; v < 2; v++) begin
      pins({1'h0, {4{v[0]}}, 3'h0});
      settle(4);
      `CHK("tap_ins", {4{v[0]}}, {tms, tdi, tck, trst_n});
    end
    @(posedge pclk);
    tap_level <= 1'h0;
    settle(2);
    `CHK("tdo_pad", 2'h0, {port4_pin_oe_n[7], port4_pin_out[7]});
    wr(PDCE_OFF_P4_LO, 32'h0000_00FF);
    settle(4);
    `CHK("trst_unused", 2'h2, {port4_pin_oe_n[3], trst_n});
    wr(PDCE_OFF_P4_HI, 32'h0000_0000);
    settle(4);
    `CHK("gpio_in", 7'h7E, {port4_pin_oe_n[7:4], tms, tdi, tck});
    wr(PDCE_OFF_P4_OUT, 32'h0000_0080);
    wr(PDCE_OFF_P4_HI, 32'h0000_0040);
    settle(2);
    `CHK("gpio_out", 2'h1, {port4_pin_oe_n[7], port4_pin_out[7]});
    $display("test debug done");
  endtask

  initial begin
    pclk = 1'h0;
    forever #10 pclk = ~pclk;
  end

  initial begin
    presetn = 1'h0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 32'h0;
    pwdata = 32'h0;
    ext_level = 8'h02;
    tap_level = 1'h1;
    wave_level = 1'h1;
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    test_reset();
    test_regs();
    test_irq();
    test_modes();
    test_debug();
    tally_and_finish();
  end
endmodule
